// *** core/fault_debounce.sv ***
// qualifies one synchronised comparator level
module fault_debounce
#(
  parameter int BASE_CYC = rail_window_pkg::DEB_BASE_CYC,
  parameter int CNT_W    = 16
)
(
  input  wire logic       clock,
  input  wire logic       arst_n,
  input  wire logic       enable,
  input  wire logic       raw,
  input  wire logic [3:0] code,
  output logic            fault
);

  // refused at elaboration: the full-code count must fit the counter
  if (BASE_CYC < 1 || (BASE_CYC << 10) >= (1 << CNT_W))
  begin : g_bad_base
    $error("fault_debounce: BASE_CYC does not fit CNT_W");
  end

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic             fault_reg;
  logic             fault_next;
  logic [CNT_W-1:0] target;

  // ----------------------------------------------------------------
  // count stable cycles; release at once, qualify only the onset
  // ----------------------------------------------------------------
  always_comb
  begin
    if (code >= rail_window_pkg::DEB_SAT_CODE)
      target = CNT_W'(BASE_CYC) << rail_window_pkg::DEB_SAT_CODE;
    else
      target = CNT_W'(BASE_CYC) << code;
    cnt_next   = cnt_reg;
    fault_next = fault_reg;
    if (!enable || !raw)
    begin
      cnt_next   = '0;
      fault_next = 1'b0;
    end
    else if (!fault_reg)
    begin
      // >= keeps a shortened time from stranding the count
      if (cnt_reg + CNT_W'(1) >= target)
        fault_next = 1'b1;
      else
        cnt_next = cnt_reg + CNT_W'(1);
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_reg   <= '0;
      fault_reg <= 1'b0;
    end
    else
    begin
      cnt_reg   <= cnt_next;
      fault_reg <= fault_next;
    end
  end

  assign fault = fault_reg;

endmodule : fault_debounce

// *** core/rail_window_fault_config.sv ***
// Summary of operation
// - with 1x scaling a threshold code means 0.2 V plus code times 5 mV.
// - with 4x scaling a threshold code means 0.8 V plus code times 20 mV.
// - all four thresholds of the channel follow the one scaling bit.
// - the fast undervoltage limit sits at 0x20 and resets to 0x00.
// - the fast overvoltage limit sits at 0x21 and resets to all ones.
// - the slow undervoltage limit sits at 0x22 and resets to zero.
// - the slow overvoltage limit sits at 0x23 and resets to all ones.
// - a fast overvoltage fault needs a stable input for bits 7:4 time.
// - a fast undervoltage fault needs a stable input for bits 3:0 time.
// - debounce is 0.1 us doubling per code, 102.4 us from code 1010b.
// - bits 4:3 route fast faults to the reset pin, reset value 10b.
// - a 3-bit cutoff code picks 250 Hz to 4 kHz, default 1 kHz.
// - the low-pass filter is set so the slow path corner is the cutoff.
// - the channel scaling bit chooses 1x on 0 and 4x on 1.
// - faults are only produced while the channel monitor is enabled.
module rail_window_fault_config
#(
  // above 4096 cycles at full code, so kept shortenable for simulation
  parameter int DEB_BASE_CYC = rail_window_pkg::DEB_BASE_CYC,
  parameter int DEB_CNT_W    = 16
)
(
  input  wire logic        clock,
  input  wire logic        arst_n,
  // register port from the serial engine
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr_en,
  input  wire logic        reg_rd_en,
  output logic      [7:0]  reg_rdata,
  output logic             reg_rd_valid,
  // channel-wide controls held elsewhere
  input  wire logic        channel_scaling_select,
  input  wire logic        channel_monitor_enable,
  // analog comparator levels, asynchronous
  input  wire logic        fast_uv_cmp,
  input  wire logic        fast_ov_cmp,
  input  wire logic        slow_uv_cmp,
  input  wire logic        slow_ov_cmp,
  // threshold codes toward the comparator DACs
  output logic      [7:0]  fast_path_undervolt_limit,
  output logic      [7:0]  fast_path_overvolt_limit,
  output logic      [7:0]  slow_path_undervolt_limit,
  output logic      [7:0]  slow_path_overvolt_limit,
  // decoded thresholds in millivolts
  output logic      [12:0] fast_undervolt_mv,
  output logic      [12:0] fast_overvolt_mv,
  output logic      [12:0] slow_undervolt_mv,
  output logic      [12:0] slow_overvolt_mv,
  // filter corner select, always a valid code
  output logic      [2:0]  slow_path_cutoff,
  // qualified faults and the reset pin
  output logic             fast_uv_fault,
  output logic             fast_ov_fault,
  output logic             slow_uv_fault,
  output logic             slow_ov_fault,
  output logic             reset_output_low
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (DEB_BASE_CYC < 1)
  begin : g_bad_base
    $error("rail_window_fault_config: DEB_BASE_CYC below one");
  end
  if ((DEB_BASE_CYC << 10) >= (1 << DEB_CNT_W))
  begin : g_bad_width
    $error("rail_window_fault_config: DEB_CNT_W too narrow");
  end

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [7:0]  fast_uv_reg;
  logic [7:0]  fast_uv_next;
  logic [7:0]  fast_ov_reg;
  logic [7:0]  fast_ov_next;
  logic [7:0]  slow_uv_reg;
  logic [7:0]  slow_uv_next;
  logic [7:0]  slow_ov_reg;
  logic [7:0]  slow_ov_next;
  logic [7:0]  debounce_reg;
  logic [7:0]  debounce_next;
  logic [1:0]  route_reg;
  logic [1:0]  route_next;
  logic [2:0]  cutoff_reg;
  logic [2:0]  cutoff_next;
  logic [7:0]  rdata_reg;
  logic [7:0]  rdata_next;
  logic        rd_valid_reg;
  logic        rd_valid_next;

  logic [3:0]  cmp_meta_reg;
  logic [3:0]  cmp_sync_reg;

  logic [12:0] fast_uv_mv_reg;
  logic [12:0] fast_ov_mv_reg;
  logic [12:0] slow_uv_mv_reg;
  logic [12:0] slow_ov_mv_reg;
  logic [12:0] fast_uv_mv;
  logic [12:0] fast_ov_mv;
  logic [12:0] slow_uv_mv;
  logic [12:0] slow_ov_mv;

  logic        slow_uv_flt_reg;
  logic        slow_uv_flt_next;
  logic        slow_ov_flt_reg;
  logic        slow_ov_flt_next;
  logic        rst_low_reg;
  logic        rst_low_next;
  logic        fast_uv_q;
  logic        fast_ov_q;
  logic [2:0]  wr_cutoff;
  logic        wr_cutoff_ok;
  logic [3:0]  ov_code;
  logic [3:0]  uv_code;

  // ----------------------------------------------------------------
  // comparator synchronisers
  // ----------------------------------------------------------------
  // bit 0 fast uv, 1 fast ov, 2 slow uv, 3 slow ov
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cmp_meta_reg <= 4'h0;
      cmp_sync_reg <= 4'h0;
    end
    else
    begin
      cmp_meta_reg <= {slow_ov_cmp, slow_uv_cmp, fast_ov_cmp, fast_uv_cmp};
      cmp_sync_reg <= cmp_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  // a bad cutoff code leaves the old corner, so the filter never
  // sees a code it cannot build
  assign wr_cutoff    = reg_wdata[rail_window_pkg::CUTOFF_LSB +: 3];
  assign wr_cutoff_ok = (wr_cutoff >= rail_window_pkg::CUT_250HZ) &&
                        (wr_cutoff <= rail_window_pkg::CUT_4KHZ);

  always_comb
  begin
    fast_uv_next  = fast_uv_reg;
    fast_ov_next  = fast_ov_reg;
    slow_uv_next  = slow_uv_reg;
    slow_ov_next  = slow_ov_reg;
    debounce_next = debounce_reg;
    route_next    = route_reg;
    cutoff_next   = cutoff_reg;
    if (reg_wr_en)
    begin
      if (reg_addr == rail_window_pkg::OFF_FAST_UV)
        fast_uv_next = reg_wdata;
      else if (reg_addr == rail_window_pkg::OFF_FAST_OV)
        fast_ov_next = reg_wdata;
      else if (reg_addr == rail_window_pkg::OFF_SLOW_UV)
        slow_uv_next = reg_wdata;
      else if (reg_addr == rail_window_pkg::OFF_SLOW_OV)
        slow_ov_next = reg_wdata;
      else if (reg_addr == rail_window_pkg::OFF_DEBOUNCE)
        debounce_next = reg_wdata;
      else if (reg_addr == rail_window_pkg::OFF_CUTOFF)
      begin
        route_next = reg_wdata[rail_window_pkg::ROUTE_LSB +: 2];
        if (wr_cutoff_ok)
          cutoff_next = wr_cutoff;
      end
    end
  end

  // ----------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------
  // unmapped offsets read as zero; reserved bits 7:5 read as zero
  always_comb
  begin
    rdata_next    = rdata_reg;
    rd_valid_next = reg_rd_en;
    if (reg_rd_en)
    begin
      if (reg_addr == rail_window_pkg::OFF_FAST_UV)
        rdata_next = fast_uv_reg;
      else if (reg_addr == rail_window_pkg::OFF_FAST_OV)
        rdata_next = fast_ov_reg;
      else if (reg_addr == rail_window_pkg::OFF_SLOW_UV)
        rdata_next = slow_uv_reg;
      else if (reg_addr == rail_window_pkg::OFF_SLOW_OV)
        rdata_next = slow_ov_reg;
      else if (reg_addr == rail_window_pkg::OFF_DEBOUNCE)
        rdata_next = debounce_reg;
      else if (reg_addr == rail_window_pkg::OFF_CUTOFF)
        rdata_next = {3'h0, route_reg, cutoff_reg};
      else
        rdata_next = 8'h00;
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fast_uv_reg  <= rail_window_pkg::RST_UV;
      fast_ov_reg  <= rail_window_pkg::RST_OV;
      slow_uv_reg  <= rail_window_pkg::RST_UV;
      slow_ov_reg  <= rail_window_pkg::RST_OV;
      debounce_reg <= rail_window_pkg::RST_DEBOUNCE;
      route_reg    <= rail_window_pkg::RST_ROUTE;
      cutoff_reg   <= rail_window_pkg::CUT_1KHZ;
      rdata_reg    <= 8'h00;
      rd_valid_reg <= 1'b0;
    end
    else
    begin
      fast_uv_reg  <= fast_uv_next;
      fast_ov_reg  <= fast_ov_next;
      slow_uv_reg  <= slow_uv_next;
      slow_ov_reg  <= slow_ov_next;
      debounce_reg <= debounce_next;
      route_reg    <= route_next;
      cutoff_reg   <= cutoff_next;
      rdata_reg    <= rdata_next;
      rd_valid_reg <= rd_valid_next;
    end
  end

  // ----------------------------------------------------------------
  // threshold decode, one scaling bit for all four
  // ----------------------------------------------------------------
  threshold_decode u_dec_fast_uv
  (
    .code       (fast_uv_reg),
    .scale_4x   (channel_scaling_select),
    .millivolts (fast_uv_mv)
  );

  threshold_decode u_dec_fast_ov
  (
    .code       (fast_ov_reg),
    .scale_4x   (channel_scaling_select),
    .millivolts (fast_ov_mv)
  );

  threshold_decode u_dec_slow_uv
  (
    .code       (slow_uv_reg),
    .scale_4x   (channel_scaling_select),
    .millivolts (slow_uv_mv)
  );

  threshold_decode u_dec_slow_ov
  (
    .code       (slow_ov_reg),
    .scale_4x   (channel_scaling_select),
    .millivolts (slow_ov_mv)
  );

  // registered so the outputs come from flops, one cycle behind
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fast_uv_mv_reg <= rail_window_pkg::MV_OFS_1X;
      fast_ov_mv_reg <= rail_window_pkg::MV_OFS_1X;
      slow_uv_mv_reg <= rail_window_pkg::MV_OFS_1X;
      slow_ov_mv_reg <= rail_window_pkg::MV_OFS_1X;
    end
    else
    begin
      fast_uv_mv_reg <= fast_uv_mv;
      fast_ov_mv_reg <= fast_ov_mv;
      slow_uv_mv_reg <= slow_uv_mv;
      slow_ov_mv_reg <= slow_ov_mv;
    end
  end

  // ----------------------------------------------------------------
  // fast path debounce
  // ----------------------------------------------------------------
  assign ov_code = debounce_reg[rail_window_pkg::OVERVOLT_DEBOUNCE_CODE_LSB +: 4];
  assign uv_code = debounce_reg[rail_window_pkg::UNDERVOLT_DEBOUNCE_CODE_LSB +: 4];

  // comparator high means below the uv limit or above the ov limit
  fault_debounce
  #(
    .BASE_CYC (DEB_BASE_CYC),
    .CNT_W    (DEB_CNT_W)
  )
  u_deb_fast_ov
  (
    .clock  (clock),
    .arst_n (arst_n),
    .enable (channel_monitor_enable),
    .raw    (cmp_sync_reg[1]),
    .code   (ov_code),
    .fault  (fast_ov_q)
  );

  fault_debounce
  #(
    .BASE_CYC (DEB_BASE_CYC),
    .CNT_W    (DEB_CNT_W)
  )
  u_deb_fast_uv
  (
    .clock  (clock),
    .arst_n (arst_n),
    .enable (channel_monitor_enable),
    .raw    (cmp_sync_reg[0]),
    .code   (uv_code),
    .fault  (fast_uv_q)
  );

  // ----------------------------------------------------------------
  // slow path faults and reset routing
  // ----------------------------------------------------------------
  // the slow path is already filtered in analog, so no debounce here
  always_comb
  begin
    slow_uv_flt_next = channel_monitor_enable && cmp_sync_reg[2];
    slow_ov_flt_next = channel_monitor_enable && cmp_sync_reg[3];
    rst_low_next   = !((route_reg[rail_window_pkg::ROUTE_UV_BIT] &&
                        fast_uv_q) ||
                       (route_reg[rail_window_pkg::ROUTE_OV_BIT] &&
                        fast_ov_q));
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      slow_uv_flt_reg <= 1'b0;
      slow_ov_flt_reg <= 1'b0;
      rst_low_reg     <= 1'b1;
    end
    else
    begin
      slow_uv_flt_reg <= slow_uv_flt_next;
      slow_ov_flt_reg <= slow_ov_flt_next;
      rst_low_reg     <= rst_low_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata                 = rdata_reg;
  assign reg_rd_valid              = rd_valid_reg;
  assign fast_path_undervolt_limit = fast_uv_reg;
  assign fast_path_overvolt_limit  = fast_ov_reg;
  assign slow_path_undervolt_limit = slow_uv_reg;
  assign slow_path_overvolt_limit  = slow_ov_reg;
  assign fast_undervolt_mv         = fast_uv_mv_reg;
  assign fast_overvolt_mv          = fast_ov_mv_reg;
  assign slow_undervolt_mv         = slow_uv_mv_reg;
  assign slow_overvolt_mv          = slow_ov_mv_reg;
  assign slow_path_cutoff          = cutoff_reg;
  assign fast_uv_fault             = fast_uv_q;
  assign fast_ov_fault             = fast_ov_q;
  assign slow_uv_fault             = slow_uv_flt_reg;
  assign slow_ov_fault             = slow_ov_flt_reg;
  assign reset_output_low          = rst_low_reg;

endmodule : rail_window_fault_config

// *** core/rail_window_pkg.sv ***
package rail_window_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_FAST_UV   = 8'h20;
  localparam logic [7:0] OFF_FAST_OV   = 8'h21;
  localparam logic [7:0] OFF_SLOW_UV   = 8'h22;
  localparam logic [7:0] OFF_SLOW_OV   = 8'h23;
  localparam logic [7:0] OFF_DEBOUNCE  = 8'h24;
  localparam logic [7:0] OFF_CUTOFF    = 8'h25;

  // ----------------------------------------------------------------
  // reset values and field layout
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_UV        = 8'h00;
  localparam logic [7:0] RST_OV        = 8'hff;
  localparam logic [7:0] RST_DEBOUNCE  = 8'h00;
  localparam logic [1:0] RST_ROUTE     = 2'h2;
  localparam int         OVERVOLT_DEBOUNCE_CODE_LSB    = 4;
  localparam int         UNDERVOLT_DEBOUNCE_CODE_LSB    = 0;
  localparam int         ROUTE_LSB     = 3;
  localparam int         CUTOFF_LSB    = 0;
  localparam int         ROUTE_UV_BIT  = 0;
  localparam int         ROUTE_OV_BIT  = 1;

  // ----------------------------------------------------------------
  // cutoff codes
  // ----------------------------------------------------------------
  localparam logic [2:0] CUT_250HZ     = 3'h2;
  localparam logic [2:0] CUT_500HZ     = 3'h3;
  localparam logic [2:0] CUT_1KHZ      = 3'h4;
  localparam logic [2:0] CUT_2KHZ      = 3'h5;
  localparam logic [2:0] CUT_4KHZ      = 3'h6;

  // ----------------------------------------------------------------
  // threshold decode, millivolts
  // ----------------------------------------------------------------
  localparam int         MV_W          = 13;
  localparam logic [12:0] MV_OFS_1X    = 13'h00c8; // 0.2 V
  localparam logic [12:0] MV_STEP_1X   = 13'h0005; // 5 mV
  localparam logic [12:0] MV_OFS_4X    = 13'h0320; // 0.8 V
  localparam logic [12:0] MV_STEP_4X   = 13'h0014; // 20 mV

  // ----------------------------------------------------------------
  // debounce timing
  // ----------------------------------------------------------------
  localparam int         CLK_MHZ       = 200;
  localparam int         DEB_BASE_NS   = 100;  // 0.1 us for code 0
  localparam int         DEB_BASE_CYC  = (DEB_BASE_NS * CLK_MHZ) / 1000;
  localparam logic [3:0] DEB_SAT_CODE  = 4'ha; // 102.4 us and above

endpackage : rail_window_pkg

// *** core/threshold_decode.sv ***
// threshold code to millivolts, one scaling per channel
module threshold_decode
(
  input  wire logic [7:0]  code,
  input  wire logic        scale_4x,
  output logic      [12:0] millivolts
);

  // ----------------------------------------------------------------
  // offset plus code times step
  // ----------------------------------------------------------------
  always_comb
  begin
    if (scale_4x)
      millivolts = rail_window_pkg::MV_OFS_4X +
                   13'(code) * rail_window_pkg::MV_STEP_4X;
    else
      millivolts = rail_window_pkg::MV_OFS_1X +
                   13'(code) * rail_window_pkg::MV_STEP_1X;
  end

endmodule : threshold_decode

// *** verification/rail_comparator_model.sv ***
// ----------------------------------------------------------------
// supply rail comparators facing the channel
// ----------------------------------------------------------------
module rail_comparator_model
(
  input  logic [12:0] fast_rail_mv,
  input  logic [12:0] slow_rail_mv,
  input  logic [12:0] fast_undervolt_mv,
  input  logic [12:0] fast_overvolt_mv,
  input  logic [12:0] slow_undervolt_mv,
  input  logic [12:0] slow_overvolt_mv,
  output logic        fast_uv_cmp,
  output logic        fast_ov_cmp,
  output logic        slow_uv_cmp,
  output logic        slow_ov_cmp
);
  timeunit 1ns;
  timeprecision 1ps;

  // ideal comparators, no hysteresis, so a limit change acts at once
  assign fast_uv_cmp = fast_rail_mv < fast_undervolt_mv;
  assign fast_ov_cmp = fast_rail_mv > fast_overvolt_mv;
  assign slow_uv_cmp = slow_rail_mv < slow_undervolt_mv;
  assign slow_ov_cmp = slow_rail_mv > slow_overvolt_mv;
endmodule : rail_comparator_model

// *** verification/rail_window_fault_config_test.sv ***
// ----------------------------------------------------------------
// self-checking bench for the channel register bank
// ----------------------------------------------------------------
module test_rail_window_fault_config;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int BASE = 2; // short debounce base keeps the run brief
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] q;} row_t;
  localparam row_t ROWS [8] = '{
    '{8'h20, 8'ha5, 8'ha5}, '{8'h21, 8'h3c, 8'h3c},
    '{8'h22, 8'hff, 8'hff}, '{8'h23, 8'h00, 8'h00},
    '{8'h24, 8'h37, 8'h37}, '{8'h25, 8'hf3, 8'h13},
    '{8'h25, 8'h0f, 8'h0b}, '{8'h30, 8'h55, 8'h00}};
  localparam logic [7:0] RSTV [6] = '{8'h00, 8'hff, 8'h00, 8'hff,
                                      8'h00, 8'h14};
  localparam logic [3:0] CODES [4] = '{4'h0, 4'h9, 4'ha, 4'hf};

  logic        clock, arst_n, reg_wr_en, reg_rd_en, reg_rd_valid;
  logic        channel_scaling_select, channel_monitor_enable;
  logic        fast_uv_cmp, fast_ov_cmp, slow_uv_cmp, slow_ov_cmp;
  logic        fast_uv_fault, fast_ov_fault, slow_uv_fault, slow_ov_fault;
  logic        reset_output_low;
  logic [2:0]  slow_path_cutoff;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic [7:0]  fast_path_undervolt_limit, fast_path_overvolt_limit;
  logic [7:0]  slow_path_undervolt_limit, slow_path_overvolt_limit;
  logic [12:0] fast_undervolt_mv, fast_overvolt_mv, fast_rail_mv;
  logic [12:0] slow_undervolt_mv, slow_overvolt_mv, slow_rail_mv;
  int          fails, n_checks;

  rail_window_fault_config #(.DEB_BASE_CYC(BASE)) u_dut (.*);
  rail_comparator_model u_rails (.*);

  task automatic check(logic [12:0] got, logic [12:0] exp, string what);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask : check

  // strobes rise and fall on falling edges, away from sampling
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge clock);
    {reg_addr, reg_wdata, reg_wr_en} = {a, d, 1'b1};
    @(negedge clock);
    reg_wr_en = 1'b0;
  endtask : wr

  task automatic rd(logic [7:0] a, logic [7:0] exp);
    @(negedge clock);
    {reg_addr, reg_rd_en} = {a, 1'b1};
    @(negedge clock);
    reg_rd_en = 1'b0;
    check({12'h000, reg_rd_valid}, 13'h0001, "read valid");
    check({5'h00, reg_rdata}, {5'h00, exp}, "read data");
  endtask : rd

  // bounded wait for onset, then pin state and release
  task automatic deb(logic ov, int n, logic rst_exp);
    int k;
    k = 0;
    fast_rail_mv = ov ? 13'h05dc : 13'h0064;
    while ((ov ? fast_ov_fault : fast_uv_fault) !== 1'b1 && k < 4000)
    begin
      @(negedge clock);
      k++;
    end
    check({12'h000, k >= n + 1 && k <= n + 4}, 13'h0001, "debounce span");
    @(negedge clock);
    check({12'h000, reset_output_low}, {12'h000, rst_exp}, "reset pin");
    fast_rail_mv = 13'h0320;
    repeat (6) @(negedge clock);
    check({12'h000, reset_output_low}, 13'h0001, "pin released");
  endtask : deb

  task automatic do_reset();
    arst_n = 1'b0;
    repeat (5) @(negedge clock);
    arst_n = 1'b1;
  endtask : do_reset

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // expected run is under 8000 cycles
  initial
  begin
    #100000;
    fails++;
    $display("[FAIL] %0t watchdog expired", $time);
    tally_and_finish();
  end

  initial
  begin
    {reg_addr, reg_wdata, reg_wr_en, reg_rd_en} = 18'h00000;
    {channel_scaling_select, channel_monitor_enable} = 2'h1;
    {fast_rail_mv, slow_rail_mv} = {2{13'h0320}};
    {fails, n_checks} = {32'sd0, 32'sd0};
    do_reset();
    foreach (ROWS[i])
    begin
      wr(ROWS[i].a, ROWS[i].d);
      rd(ROWS[i].a, ROWS[i].q);
    end
    check({10'h000, slow_path_cutoff}, 13'h0003, "cutoff kept");
    check({5'h00, slow_path_undervolt_limit}, 13'h00ff, "slow uv code");
    $display("row table done");
    do_reset();
    foreach (RSTV[i])
      rd(8'h20 + 8'(i), RSTV[i]);
    check(fast_undervolt_mv, 13'h00c8, "uv mv after reset");
    $display("reset values done");
    wr(8'h21, 8'hff);
    repeat (2) @(negedge clock);
    check(fast_overvolt_mv, 13'h05c3, "1x top code");
    channel_scaling_select = 1'b1;
    repeat (2) @(negedge clock);
    check(fast_overvolt_mv, 13'h170c, "4x top code");
    check(slow_undervolt_mv, 13'h0320, "4x zero code");
    channel_scaling_select = 1'b0;
    $display("decode done");
    wr(8'h25, 8'h1c);
    foreach (CODES[i])
    begin
      wr(8'h24, {CODES[i], 4'h0});
      deb(1'b1, BASE << ((CODES[i] > 4'h9) ? 10 : CODES[i]), 1'b0);
    end
    wr(8'h24, 8'h0b);
    deb(1'b0, BASE << 10, 1'b0);
    wr(8'h25, 8'h04);
    wr(8'h24, 8'h00);
    deb(1'b1, BASE, 1'b1);
    $display("debounce done");
    channel_monitor_enable = 1'b0;
    {fast_rail_mv, slow_rail_mv} = {2{13'h05dc}};
    repeat (20) @(negedge clock);
    check({12'h000, fast_ov_fault | slow_ov_fault}, 13'h0000, "off");
    channel_monitor_enable = 1'b1;
    repeat (10) @(negedge clock);
    check({11'h000, fast_ov_fault, slow_ov_fault}, 13'h0003, "on");
    {fast_rail_mv, slow_rail_mv} = {2{13'h0320}};
    $display("monitor enable done");
    tally_and_finish();
  end
endmodule : test_rail_window_fault_config

// *** verification/rail_window_props.sv ***
// ----------------------------------------------------------------
// port checker for the channel register bank
// ----------------------------------------------------------------
module rail_window_props
#(
  parameter int DEB_BASE_CYC = rail_window_pkg::DEB_BASE_CYC
)
(
  input logic        clock,
  input logic        arst_n,
  input logic [7:0]  reg_addr,
  input logic [7:0]  reg_wdata,
  input logic        reg_wr_en,
  input logic        reg_rd_en,
  input logic        reg_rd_valid,
  input logic        channel_scaling_select,
  input logic        channel_monitor_enable,
  input logic        fast_uv_cmp,
  input logic        fast_ov_cmp,
  input logic        slow_uv_cmp,
  input logic [7:0]  fast_path_undervolt_limit,
  input logic [7:0]  fast_path_overvolt_limit,
  input logic [7:0]  slow_path_overvolt_limit,
  input logic [12:0] fast_undervolt_mv,
  input logic [12:0] slow_overvolt_mv,
  input logic [2:0]  slow_path_cutoff,
  input logic        fast_uv_fault,
  input logic        fast_ov_fault,
  input logic        slow_uv_fault,
  input logic        slow_ov_fault,
  input logic        reset_output_low
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0]  deb_reg, deb_next;
  logic [1:0]  route_reg, route_next;
  logic [11:0] ov_run_reg, ov_run_next, uv_run_reg, uv_run_next;

  function automatic logic [12:0] dec(logic [7:0] c, logic s);
    return s ? 13'h0320 + 13'h0014 * c : 13'h00c8 + 13'h0005 * c;
  endfunction : dec

  function automatic int need(logic [3:0] c);
    return DEB_BASE_CYC << ((c > 4'h9) ? 10 : c);
  endfunction : need

  // field mirrors and high-run counters; wrap past 4095 is harmless only while every need() stays below 4096
  always_comb
  begin
    deb_next    = deb_reg;
    route_next  = route_reg;
    ov_run_next = (fast_ov_cmp && channel_monitor_enable) ?
                  ov_run_reg + 12'h001 : 12'h000;
    uv_run_next = (fast_uv_cmp && channel_monitor_enable) ?
                  uv_run_reg + 12'h001 : 12'h000;
    if (reg_wr_en && reg_addr == rail_window_pkg::OFF_DEBOUNCE)
      deb_next = reg_wdata;
    if (reg_wr_en && reg_addr == rail_window_pkg::OFF_CUTOFF)
      route_next = reg_wdata[4:3];
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      deb_reg    <= 8'h00;
      route_reg  <= 2'h2;
      ov_run_reg <= 12'h000;
      uv_run_reg <= 12'h000;
    end
    else
    begin
      deb_reg    <= deb_next;
      route_reg  <= route_next;
      ov_run_reg <= ov_run_next;
      uv_run_reg <= uv_run_next;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  read_valid_a:
    assert property ($past(arst_n) |-> reg_rd_valid == $past(reg_rd_en))
    else $error("read valid not one cycle after strobe");
  ov_limit_a:
    assert property (reg_wr_en && reg_addr == rail_window_pkg::OFF_FAST_OV
      |=> fast_path_overvolt_limit == $past(reg_wdata))
    else $error("overvolt limit write lost");
  uv_decode_a:
    assert property ($past(arst_n) |-> fast_undervolt_mv ==
      dec($past(fast_path_undervolt_limit), $past(channel_scaling_select)))
    else $error("fast undervolt decode wrong");
  ov_decode_a:
    assert property ($past(arst_n) |-> slow_overvolt_mv ==
      dec($past(slow_path_overvolt_limit), $past(channel_scaling_select)))
    else $error("slow overvolt decode wrong");
  cutoff_valid_a:
    assert property (slow_path_cutoff inside {[3'h2:3'h6]})
    else $error("cutoff code invalid");
  monitor_off_a:
    assert property (!channel_monitor_enable |=> !fast_uv_fault &&
      !fast_ov_fault && !slow_uv_fault && !slow_ov_fault)
    else $error("fault while monitor off");
  slow_cause_a:
    assert property (slow_uv_fault |->
      $past(slow_uv_cmp, 3) && $past(channel_monitor_enable))
    else $error("slow undervolt fault without cause");
  reset_route_a:
    assert property ($past(arst_n) |-> reset_output_low ==
      !$past(route_reg[0] && fast_uv_fault || route_reg[1] && fast_ov_fault))
    else $error("reset pin does not follow routed faults");
  overvolt_debounce_code_min_a:
    assert property ($rose(fast_ov_fault) |-> ov_run_reg >= need(deb_reg[7:4]))
    else $error("overvolt fault before debounce time");
  overvolt_debounce_code_max_a:
    assert property (ov_run_reg == need(deb_reg[7:4]) + 4 |-> fast_ov_fault)
    else $error("overvolt fault late");
  undervolt_debounce_code_min_a:
    assert property ($rose(fast_uv_fault) |-> uv_run_reg >= need(deb_reg[3:0]))
    else $error("undervolt fault before debounce time");
endmodule : rail_window_props

bind rail_window_fault_config rail_window_props
  #(.DEB_BASE_CYC(DEB_BASE_CYC)) u_props (.*);
